// File: hdl/dss_sequencer.sv
// Stop, braking, pre-excitation and restart sequencer of the drive, with its register port.
// Assumes synchronous inputs from the power stage and a classic Wishbone master.
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "dss_map.svh"
module dss_sequencer #(
	parameter int unsigned TICK_CYCLES = `DSS_TICK_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic run_cmd,
	input wire logic fault_in,
	input wire logic ext_bb,
	input wire logic power_loss,
	input wire logic [5:0] mfi_in,
	input wire logic [9:0] bus_voltage,
	input wire logic [15:0] out_freq,
	input wire logic flux_ok,
	input wire logic search_done,
	output logic bridge_on,
	output logic dcb_active,
	output logic [7:0] dcb_current,
	output logic prex_active,
	output logic [7:0] prex_level,
	output logic decel_active,
	output logic [15:0] decel_ticks,
	output logic search_active,
	output logic start_from_min,
	output dss_pkg::dss_state_t seq_state,
	output logic undervoltage_fault,
	output logic input_assign_conflict_warning
);
	import dss_pkg::*;

	localparam dss_regs_t RST_VAL = '{
		state: ST_IDLE,
		bb_next: ST_IDLE,
		ctrl: `DSS_RST_CTRL,
		freq: `DSS_RST_FREQ,
		dcb: `DSS_RST_DCB,
		brkt: `DSS_RST_BRKT,
		times: `DSS_RST_TIME,
		prex: `DSS_RST_PREX,
		lowv: `DSS_RST_LOWV,
		mfil: `DSS_RST_MFI,
		mfih: `DSS_RST_MFI,
		default: '0
	};

	dss_regs_t s; // Registered state
	dss_regs_t n; // Next state
	logic tick; // Common timer tick
	dss_stop_t stop_sel; // Effective stop mode
	logic sensor_vector_mode; // Closed-loop vector control selected
	logic sensorless_vector_mode; // Open-loop vector control selected
	logic ride_thru; // Momentary power loss ride-through on
	logic lowv_below; // Bus below detection level
	logic lowv_trip; // Undervoltage detected this cycle
	logic mfi_dcb; // Input braking command present
	logic active; // Output bridge sequencing a run or stop
	logic in_bb; // Any output-off hold
	logic [15:0] brake_freq; // Frequency at which stop braking starts
	logic [47:0] mfi_codes; // Function codes of the six inputs
	logic [5:0] reg_idx; // Word index on the bus

	// Frequency times duration over maximum, saturating
	function automatic logic [15:0] dss_scale(input logic [15:0] f, input logic [15:0] fmax,
		input logic [15:0] t);
		logic [31:0] prod;
		logic [31:0] q;
		prod = 32'(f) * 32'(t);
		q = (fmax == 16'h0000) ? 32'(t) : prod / 32'(fmax);
		dss_scale = (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
	endfunction : dss_scale

	// Any selected input carrying a given function code
	function automatic logic dss_has(input logic [47:0] codes, input logic [5:0] mask,
		input logic [5:0] code);
		dss_has = 1'b0;
		for (int i = 0; i < 6; i++) begin
			if (mask[i] && codes[i*8 +: 6] == code) begin
				dss_has = 1'b1;
			end
		end
	endfunction : dss_has

	// Byte-lane write merge
	function automatic logic [31:0] dss_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		dss_merge = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				dss_merge[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction : dss_merge

	// First state of a start sequence
	function automatic dss_state_t dss_start(input logic ss, input logic [15:0] brk_t,
		input logic [15:0] prex_t, input logic sensor);
		if (ss) begin
			dss_start = ST_SEARCH;
		end else if (brk_t != 16'h0000 && !sensor) begin
			dss_start = ST_DCB_START;
		end else if (prex_t != 16'h0000) begin
			dss_start = ST_PREX;
		end else begin
			dss_start = ST_RUN;
		end
	endfunction : dss_start

	// Common tick for every timer
	dss_tick_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.tick(tick)
	);

	// Configuration decode
	assign sensor_vector_mode = s.ctrl[`DSS_F_CTRL_MODE] == `DSS_CM_SNS;
	assign sensorless_vector_mode = s.ctrl[`DSS_F_CTRL_MODE] == `DSS_CM_SLV;
	assign ride_thru = s.ctrl[`DSS_F_RIDE_THRU];
	assign stop_sel = s.ctrl[`DSS_F_PM_MOTOR] ? STOP_DECEL : dss_stop_t'(s.ctrl[`DSS_F_STOP_MODE]);
	assign mfi_codes = {s.mfih[`DSS_F_LO16], s.mfil};
	assign mfi_dcb = dss_has(mfi_codes, mfi_in, `DSS_FN_DCB);
	assign reg_idx = wb_adr_i[7:2];

	// Braking begins at the higher of braking and minimum frequency
	assign brake_freq = ({8'h00, s.dcb[`DSS_F_BYTE0]} < s.freq[`DSS_F_LO16]) ?
		s.freq[`DSS_F_LO16] : {8'h00, s.dcb[`DSS_F_BYTE0]};

	// Undervoltage filter
	assign lowv_below = !ride_thru && ({6'h00, bus_voltage} < s.lowv[`DSS_F_LO16]);
	assign lowv_trip = lowv_below && (s.lowv[`DSS_F_HI16] == 16'h0000 ||
		s.lowv_cnt >= s.lowv[`DSS_F_HI16]);

	// States that drive the bridge or hold it off
	assign active = s.state inside {ST_DCB_START, ST_PREX, ST_SEARCH, ST_RUN, ST_DECEL, ST_DCB_STOP};
	assign in_bb = s.state inside {ST_BB, ST_EXT_BB, ST_LOSS};

	// Next-state logic
	always_comb begin
		n = s;
		n.run_prev = run_cmd;
		n.ack = wb_cyc_i & wb_stb_i & ~s.ack;

		// Timers advance on the tick only
		if (tick) begin
			if (s.tmr != 16'h0000) begin
				n.tmr = s.tmr - 16'h0001;
			end
			if (s.inh_cnt != 16'h0000) begin
				n.inh_cnt = s.inh_cnt - 16'h0001;
			end
			if (power_loss && s.loss_cnt != 16'hFFFF) begin
				n.loss_cnt = s.loss_cnt + 16'h0001;
			end
		end
		if (!lowv_below) begin
			n.lowv_cnt = 16'h0000;
		end else if (tick && s.lowv_cnt != 16'hFFFF) begin
			n.lowv_cnt = s.lowv_cnt + 16'h0001;
		end

		// Register access
		if (n.ack) begin
			n.rdata = 32'h0000_0000;
			unique case (reg_idx)
				`DSS_OFS_CTRL: n.rdata = s.ctrl;
				`DSS_OFS_FREQ: n.rdata = s.freq;
				`DSS_OFS_DCB: n.rdata = s.dcb;
				`DSS_OFS_BRKT: n.rdata = s.brkt;
				`DSS_OFS_TIME: n.rdata = s.times;
				`DSS_OFS_PREX: n.rdata = s.prex;
				`DSS_OFS_LOWV: n.rdata = s.lowv;
				`DSS_OFS_MFIL: n.rdata = s.mfil;
				`DSS_OFS_MFIH: n.rdata = s.mfih;
				`DSS_OFS_STAT: n.rdata = {s.tmr, s.inh_cnt[7:0], (s.inh_cnt != 16'h0000),
					s.ss_pend, input_assign_conflict_warning, s.undervoltage_fault, s.state};
				default: n.rdata = 32'h0000_0000; // Unmapped reads zero
			endcase
			if (wb_we_i) begin
				unique case (reg_idx)
					`DSS_OFS_CTRL: n.ctrl = dss_merge(s.ctrl, wb_dat_i, wb_sel_i);
					`DSS_OFS_FREQ: n.freq = dss_merge(s.freq, wb_dat_i, wb_sel_i);
					`DSS_OFS_DCB: n.dcb = dss_merge(s.dcb, wb_dat_i, wb_sel_i);
					`DSS_OFS_BRKT: n.brkt = dss_merge(s.brkt, wb_dat_i, wb_sel_i);
					`DSS_OFS_TIME: n.times = dss_merge(s.times, wb_dat_i, wb_sel_i);
					`DSS_OFS_PREX: n.prex = dss_merge(s.prex, wb_dat_i, wb_sel_i);
					`DSS_OFS_LOWV: n.lowv = dss_merge(s.lowv, wb_dat_i, wb_sel_i);
					`DSS_OFS_MFIL: n.mfil = dss_merge(s.mfil, wb_dat_i, wb_sel_i);
					`DSS_OFS_MFIH: n.mfih = dss_merge(s.mfih, wb_dat_i, wb_sel_i);
					`DSS_OFS_CLR: begin
						if (wb_sel_i[0] && wb_dat_i[`DSS_F_CLR_FAULT]) begin
							n.undervoltage_fault = 1'b0;
						end
					end
					default: n.ctrl = s.ctrl; // Unmapped writes ignored
				endcase
			end
		end

		// A new detection beats a same-cycle clear
		if (lowv_trip) begin
			n.undervoltage_fault = 1'b1;
		end

		// Sequencer
		unique case (s.state)
			ST_IDLE: begin
				// Start only on a fresh run edge, after timers and faults clear
				if (run_cmd && !s.run_prev && !s.undervoltage_fault &&
					s.inh_cnt == 16'h0000) begin
					n.state = dss_start(s.ss_pend, s.brkt[`DSS_F_HI16], s.prex[`DSS_F_LO16],
						sensor_vector_mode);
					n.from_min = 1'b1;
				end
			end
			ST_DCB_START: begin
				// Start braking done, go on to pre-excitation or run
				if (s.tmr == 16'h0000) begin
					n.state = (s.prex[`DSS_F_LO16] != 16'h0000) ? ST_PREX : ST_RUN;
				end
			end
			ST_PREX: begin
				// Flux at full or time out ends pre-excitation
				if (flux_ok || s.tmr == 16'h0000) begin
					n.state = ST_RUN;
				end
			end
			ST_SEARCH: begin
				// Resume from the found speed
				if (search_done) begin
					n.state = ST_RUN;
					n.ss_pend = 1'b0;
					n.from_min = 1'b0;
				end
			end
			ST_RUN: begin
				// Stop command handling per mode
				if (!run_cmd) begin
					n.bb_next = ST_IDLE;
					unique case (stop_sel)
						STOP_DECEL: begin
							n.state = ST_DECEL;
							n.decel_len = dss_scale(out_freq, s.freq[`DSS_F_HI16],
								s.times[`DSS_F_LO16]);
						end
						STOP_COAST: begin
							n.state = ST_BB;
							if (sensorless_vector_mode && !s.ctrl[`DSS_F_SRCH_OFF]) begin
								n.ss_pend = 1'b1;
							end
						end
						STOP_DCB: begin
							n.state = ST_BB;
							n.dcb_len = dss_scale(out_freq, s.freq[`DSS_F_HI16],
								s.brkt[`DSS_F_LO16]);
							n.bb_next = sensor_vector_mode ? ST_IDLE : ST_DCB_STOP;
						end
						STOP_COAST_TMR: begin
							n.state = ST_BB;
							n.inh_cnt = dss_scale(out_freq, s.freq[`DSS_F_HI16],
								s.times[`DSS_F_LO16]);
							if (sensorless_vector_mode && !s.ctrl[`DSS_F_SRCH_OFF]) begin
								n.ss_pend = 1'b1;
							end
						end
					endcase
				end
			end
			ST_DECEL: begin
				// Brake once the ramp reaches the braking point
				if (out_freq <= brake_freq) begin
					n.dcb_len = s.brkt[`DSS_F_LO16];
					n.state = (s.brkt[`DSS_F_LO16] != 16'h0000 && !sensor_vector_mode) ?
						ST_DCB_STOP : ST_IDLE;
				end
			end
			ST_DCB_STOP: begin
				// Stop braking for its duration
				if (s.tmr == 16'h0000) begin
					n.state = ST_IDLE;
				end
			end
			ST_BB: begin
				// Output off for the minimum baseblock time
				if (s.tmr == 16'h0000) begin
					n.state = s.bb_next;
				end
			end
			ST_EXT_BB: begin
				// External output-off removed
				if (!ext_bb) begin
					if (!s.ctrl[`DSS_F_AFTER_BB] && !s.ctrl[`DSS_F_PM_MOTOR]) begin
						n.ss_pend = 1'b1;
					end
					n.state = run_cmd ? dss_start(n.ss_pend, s.brkt[`DSS_F_HI16],
						s.prex[`DSS_F_LO16], sensor_vector_mode) : ST_IDLE;
				end
			end
			ST_LOSS: begin
				// Wait for power to return, search if the loss was long
				if (!power_loss) begin
					if (s.loss_cnt > s.times[`DSS_F_HI16]) begin
						n.ss_pend = 1'b1;
					end
					n.state = run_cmd ? dss_start(n.ss_pend, s.brkt[`DSS_F_HI16],
						s.prex[`DSS_F_LO16], sensor_vector_mode) : ST_IDLE;
				end
			end
			default: n.state = ST_IDLE; // Illegal code recovery
		endcase

		// Trips and output-off commands override the sequence
		if (active) begin
			if (fault_in || lowv_trip) begin
				n.state = ST_BB;
				n.bb_next = ST_IDLE;
				if (fault_in && sensorless_vector_mode && !s.ctrl[`DSS_F_AFTER_FAULT]) begin
					n.ss_pend = 1'b1;
				end
			end else if (ride_thru && power_loss) begin
				n.state = ST_BB;
				n.bb_next = ST_LOSS;
				n.loss_cnt = 16'h0000;
			end else if (ext_bb) begin
				n.state = ST_EXT_BB;
			end
		end

		// Load the timer on entry to a timed state
		if (n.state != s.state) begin
			if (n.state == ST_DCB_START) begin
				n.tmr = s.brkt[`DSS_F_HI16];
			end else if (n.state == ST_PREX) begin
				n.tmr = s.prex[`DSS_F_LO16];
			end else if (n.state == ST_DCB_STOP) begin
				n.tmr = n.dcb_len;
			end else if (n.state == ST_BB) begin
				n.tmr = s.times[`DSS_F_HI16];
			end
		end
	end

	// State register, frozen while the enable is low
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= RST_VAL;
		end else if (clk_en) begin
			s <= n;
		end
	end

	// Bus outputs
	assign wb_dat_o = s.rdata;
	assign wb_ack_o = s.ack;

	// Power stage outputs
	assign dcb_active = !sensor_vector_mode && (s.state inside {ST_DCB_START, ST_DCB_STOP} ||
		(mfi_dcb && !in_bb));
	assign bridge_on = active || dcb_active;
	assign dcb_current = s.dcb[`DSS_F_BYTE1];
	assign prex_active = s.state == ST_PREX;
	assign prex_level = s.prex[`DSS_F_LEVEL];
	assign decel_active = s.state == ST_DECEL;
	assign decel_ticks = s.decel_len;
	assign search_active = s.state == ST_SEARCH;
	assign start_from_min = s.state == ST_RUN && s.from_min;
	assign seq_state = s.state;
	assign undervoltage_fault = s.undervoltage_fault;
	assign input_assign_conflict_warning = dss_has(mfi_codes, `DSS_ALL_INPUTS, `DSS_FN_SRCH1) &&
		dss_has(mfi_codes, `DSS_ALL_INPUTS, `DSS_FN_SRCH2);

endmodule : dss_sequencer

// File: common/dss_map.svh
// Offsets, field positions, reset values and timing counts of the stop/restart sequencer.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone register port.
// How it works
// - Zero start braking time starts from minimum frequency
// - Low braking frequency brakes at minimum frequency
// - No DC braking in sensor vector mode
// - Input function 33 commands DC braking
// - Stop modes: decel, coast, braking, timed coast
// - Permanent magnet motor always decelerates to stop
// - Decel stop brakes at braking or minimum frequency
// - Decel time scaled by stop frequency over maximum
// - Coast stop refuses run until baseblock ends
// - Sensorless coast stop searches speed next start
// - Braking stop: baseblock, then scaled DC braking
// - Timed coast ignores run until timer expires
// - Undervoltage fault after filter time, zero immediate
// - No automatic restart after undervoltage shutdown
// - Run command applies timed pre-excitation
// - Pre-excitation ends when flux reaches full
// - Power failure holds output off minimum baseblock
// - Long power failure searches speed on return
// - Codes 19 and 34 together raise warning
// - Fault start select: 0 search in sensorless vector mode, 1 normal
// - External baseblock removal searches when select 0, except with PM motor
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH

// Clock and tick timing
`define DSS_CLK_NS 40
`define DSS_TICK_NS 10000000
`define DSS_TICK_CYC (`DSS_TICK_NS / `DSS_CLK_NS)

// Register word offsets
`define DSS_OFS_CTRL 6'h00
`define DSS_OFS_FREQ 6'h01
`define DSS_OFS_DCB 6'h02
`define DSS_OFS_BRKT 6'h03
`define DSS_OFS_TIME 6'h04
`define DSS_OFS_PREX 6'h05
`define DSS_OFS_LOWV 6'h06
`define DSS_OFS_MFIL 6'h07
`define DSS_OFS_MFIH 6'h08
`define DSS_OFS_STAT 6'h09
`define DSS_OFS_CLR 6'h0A

// Field positions
`define DSS_F_STOP_MODE 1:0
`define DSS_F_CTRL_MODE 3:2
`define DSS_F_PM_MOTOR 4
`define DSS_F_AFTER_FAULT 5
`define DSS_F_AFTER_BB 6
`define DSS_F_SRCH_OFF 7
`define DSS_F_RIDE_THRU 8
`define DSS_F_LO16 15:0
`define DSS_F_HI16 31:16
`define DSS_F_LEVEL 23:16
`define DSS_F_BYTE0 7:0
`define DSS_F_BYTE1 15:8
`define DSS_F_CLR_FAULT 0

// Reset values
`define DSS_RST_CTRL 32'h0000_0000
`define DSS_RST_FREQ 32'h0258_000F
`define DSS_RST_DCB 32'h0000_3205
`define DSS_RST_BRKT 32'h0000_0032
`define DSS_RST_TIME 32'h0032_03E8
`define DSS_RST_PREX 32'h0064_0000
`define DSS_RST_LOWV 32'h0032_0190
`define DSS_RST_MFI 32'h0000_0000

// Codes
`define DSS_CM_SLV 2'h2
`define DSS_CM_SNS 2'h3
`define DSS_FN_DCB 6'h21
`define DSS_FN_SRCH1 6'h13
`define DSS_FN_SRCH2 6'h22
`define DSS_ALL_INPUTS 6'h3F

`endif

// File: common/dss_pkg.sv
// Types of the stop/restart sequencer: stop modes, sequencer states and the state record.
// Assumes dss_map.svh supplies the numeric constants.
package dss_pkg;

	// Stop mode selector decode
	typedef enum logic [1:0] {
		STOP_DECEL = 2'b00,
		STOP_COAST = 2'b01,
		STOP_DCB = 2'b10,
		STOP_COAST_TMR = 2'b11
	} dss_stop_t;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_DCB_START = 4'b0001,
		ST_PREX = 4'b0010,
		ST_SEARCH = 4'b0011,
		ST_RUN = 4'b0100,
		ST_DECEL = 4'b0101,
		ST_DCB_STOP = 4'b0110,
		ST_BB = 4'b0111,
		ST_EXT_BB = 4'b1000,
		ST_LOSS = 4'b1001
	} dss_state_t;

	// Whole state of the sequencer
	typedef struct packed {
		dss_state_t state;
		dss_state_t bb_next;
		logic [15:0] tmr;
		logic [15:0] inh_cnt;
		logic [15:0] lowv_cnt;
		logic [15:0] loss_cnt;
		logic [15:0] dcb_len;
		logic [15:0] decel_len;
		logic run_prev;
		logic ss_pend;
		logic from_min;
		logic undervoltage_fault;
		logic ack;
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic [31:0] freq;
		logic [31:0] dcb;
		logic [31:0] brkt;
		logic [31:0] times;
		logic [31:0] prex;
		logic [31:0] lowv;
		logic [31:0] mfil;
		logic [31:0] mfih;
	} dss_regs_t;

endpackage : dss_pkg

// File: hdl/dss_tick_gen.sv
// Fixed-period tick generator feeding all second-based timers.
// Assumes a free-running system clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module dss_tick_gen #(
	parameter int unsigned TICK_CYCLES = 250000
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	output logic tick
);
	import dss_pkg::*;

	logic [19:0] cnt_reg; // Cycles into the current tick period
	logic [19:0] cnt_next;
	logic tick_reg; // One-cycle tick pulse
	logic tick_next;

	// Count one period, pulse at its end
	always_comb begin
		if (cnt_reg >= 20'(TICK_CYCLES - 1)) begin
			cnt_next = 20'h00000;
			tick_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + 20'h00001;
			tick_next = 1'b0;
		end
	end

	// Register, frozen while the enable is low
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= 20'h00000;
			tick_reg <= 1'b0;
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg & clk_en;

endmodule : dss_tick_gen

// File: verification/dss_sequencer_chk.sv
// Port checker of the stop/restart sequencer: bus handshake and state outputs.
// Assumes it is bound into dss_sequencer and clk_en is held high.
`timescale 1ns/10ps
module dss_sequencer_chk (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic bridge_on,
	input wire logic dcb_active,
	input wire logic prex_active,
	input wire logic decel_active,
	input wire logic search_active,
	input wire logic start_from_min,
	input dss_pkg::dss_state_t seq_state,
	input wire logic undervoltage_fault
);
	import dss_pkg::*;
	// One clock domain, one reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Ack is a single pulse
	a_ack_one_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	// A taken request is answered next cycle
	a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
		else $error("request not answered");
	// Output off during baseblock
	a_bb_bridge_off: assert property (seq_state == ST_BB |-> !bridge_on)
		else $error("bridge on in baseblock");
	// Baseblock lasts at least nine cycles
	a_bb_min_hold: assert property ($rose(seq_state == ST_BB) |=> (seq_state == ST_BB) [*8])
		else $error("baseblock too short");
	// Stop braking state drives braking, no ramp
	a_dcb_stop_brakes: assert property (seq_state == ST_DCB_STOP |-> dcb_active && !decel_active)
		else $error("braking state without braking");
	// Ramp flag follows decel state
	a_decel_ramp_flag: assert property (seq_state == ST_DECEL |-> decel_active && bridge_on)
		else $error("decel state without ramp");
	// Pre-excitation flag follows state
	a_prex_flag_set: assert property (seq_state == ST_PREX |-> prex_active)
		else $error("pre-excitation flag missing");
	// Search flag follows state
	a_search_flag_set: assert property (seq_state == ST_SEARCH |-> search_active)
		else $error("search flag missing");
	// Minimum-frequency start only while running
	a_min_start_run: assert property (start_from_min |-> seq_state == ST_RUN)
		else $error("min start outside run");
	// Fault stays until a bus write
	a_uv_fault_sticky: assert property (undervoltage_fault && !(wb_cyc_i && wb_we_i)
		|=> undervoltage_fault)
		else $error("undervoltage fault dropped");
	// No start while faulted
	a_uv_no_start: assert property (undervoltage_fault && seq_state == ST_IDLE
		|=> seq_state == ST_IDLE)
		else $error("start with undervoltage fault");
endmodule : dss_sequencer_chk

bind dss_sequencer dss_sequencer_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_ack_o(wb_ack_o), .bridge_on(bridge_on), .dcb_active(dcb_active),
	.prex_active(prex_active), .decel_active(decel_active), .search_active(search_active),
	.start_from_min(start_from_min), .seq_state(seq_state),
	.undervoltage_fault(undervoltage_fault));

// File: verification/dss_power_stage.sv
// Behavioural power stage: output frequency, flux and search replies.
// Assumes synchronous level outputs of the sequencer; delay sets reply speed.
`timescale 1ns/10ps
module dss_power_stage (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic bridge_on,
	input wire logic decel_active,
	input wire logic prex_active,
	input wire logic search_active,
	input wire logic [15:0] run_freq,
	input wire logic [7:0] delay,
	output logic [15:0] out_freq,
	output logic flux_ok,
	output logic search_done
);
	logic [7:0] cnt_reg; // Cycles in pre-excitation or search
	// Frequency follows ramp, drive or coasting decay
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_freq <= 16'h0000;
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= (prex_active || search_active) ? cnt_reg + 8'h01 : 8'h00;
			if (decel_active) begin
				out_freq <= (out_freq > 16'h0008) ? out_freq - 16'h0008 : 16'h0000;
			end else if (bridge_on) begin
				out_freq <= run_freq;
			end else if (out_freq != 16'h0000) begin
				out_freq <= out_freq - 16'h0001;
			end
		end
	end
	// Replies only while asked, low otherwise
	assign flux_ok = prex_active && (cnt_reg >= delay);
	assign search_done = search_active && (cnt_reg >= delay);
endmodule : dss_power_stage

// File: verification/dss_sequencer_bench.sv
// Self-checking bench of the stop/restart sequencer with a power stage model.
// Assumes a 10-cycle tick and classic Wishbone single cycles.
`timescale 1ns/10ps
`include "dss_map.svh"
`define DSS_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
module dss_sequencer_bench;
	import dss_pkg::*;
	logic ref_clk, reset_n, cyc, stb, we, run_cmd, flux_ok, search_done, flt;
	logic [7:0] adr, delay;
	logic [31:0] dat, q;
	logic [5:0] mfi_in;
	logic [9:0] bus_voltage;
	logic [15:0] out_freq, run_freq, f;
	logic [31:0] wb_dat_o, ctab [0:4];
	logic wb_ack_o, bridge_on, dcb_active, prex_active, decel_active, search_active;
	logic start_from_min, undervoltage_fault, warn;
	logic [7:0] dcb_current, prex_level;
	logic [15:0] decel_ticks;
	dss_state_t seq_state;
	int failures, n_checks, k;
	logic [31:0] rtab [0:8] = '{`DSS_RST_CTRL, `DSS_RST_FREQ, `DSS_RST_DCB, `DSS_RST_BRKT,
		`DSS_RST_TIME, `DSS_RST_PREX, `DSS_RST_LOWV, `DSS_RST_MFI, `DSS_RST_MFI};
	// Design with a short tick
	dss_sequencer #(.TICK_CYCLES(10)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.run_cmd(run_cmd), .fault_in(flt), .ext_bb(1'b0), .power_loss(1'b0),
		.mfi_in(mfi_in), .bus_voltage(bus_voltage), .out_freq(out_freq), .flux_ok(flux_ok),
		.search_done(search_done), .bridge_on(bridge_on), .dcb_active(dcb_active),
		.dcb_current(dcb_current), .prex_active(prex_active), .prex_level(prex_level),
		.decel_active(decel_active), .decel_ticks(decel_ticks), .search_active(search_active),
		.start_from_min(start_from_min), .seq_state(seq_state),
		.undervoltage_fault(undervoltage_fault), .input_assign_conflict_warning(warn));
	// Far-side power stage
	dss_power_stage u_stage (.ref_clk(ref_clk), .reset_n(reset_n), .bridge_on(bridge_on),
		.decel_active(decel_active), .prex_active(prex_active), .search_active(search_active),
		.run_freq(run_freq), .delay(delay), .out_freq(out_freq), .flux_ok(flux_ok),
		.search_done(search_done));
	// Free-running 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Verdict and end of run
	task test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : test_done
	// One classic Wishbone cycle, held until ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin @(posedge ref_clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge ref_clk);
		if (n >= 50) begin failures++; test_done(); end
	endtask : wb
	// Bounded wait for a sequencer state
	task wait_state(input dss_state_t st);
		int n;
		n = 0;
		while (seq_state !== st && n < 30000) begin @(posedge ref_clk); #1; n++; end
		if (n >= 30000) begin failures++; $display("wrong value wait %0h", st); test_done(); end
	endtask : wait_state
	// Clock edges then settle
	task ticks(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : ticks
	// First state after a stop command
	function automatic dss_state_t exp_stop(input logic [31:0] c);
		if (c[4] || c[1:0] == 2'b00) return ST_DECEL;
		return ST_BB;
	endfunction : exp_stop
	// Scaled duration, saturating
	function automatic logic [15:0] exp_scale(input logic [15:0] fr, input int t, input int fm);
		int r;
		r = fr * t / fm;
		return (r > 65535) ? 16'hFFFF : r[15:0];
	endfunction : exp_scale
	// Main sequence
	initial begin
		reset_n = 1'b0;
		{cyc, stb, we, run_cmd, flt} = 5'h0;
		adr = 8'h00;
		dat = 32'h0000_0000;
		delay = 8'h08;
		run_freq = 16'h0000;
		void'($urandom(32'h941b463f));
		mfi_in = 6'($urandom);
		bus_voltage = 10'd420 + 10'($urandom_range(380));
		ctab = '{32'h0, 32'h2, 32'h3, 32'h11, 32'h9};
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 9; i++) begin
			wb(1'b0, 8'(i * 4), 32'h0);
			`DSS_CHK("reset reg", rtab[i], q)
		end
		wb(1'b1, 8'h2C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h2C, 32'h0);
		`DSS_CHK("unmapped", 32'h0, q)
		wb(1'b1, 8'h10, 32'h0005_003C);
		// Decel, braking and timed coast stops, then PM and sensorless coast
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, 8'h00, ctab[i]);
			f = 16'd100 + 16'($urandom_range(500));
			run_freq <= f;
			run_cmd <= 1'b1;
			wait_state(ST_RUN);
			`DSS_CHK("min start", 1'b1, start_from_min)
			ticks(3);
			run_cmd <= 1'b0;
			ticks(2);
			`DSS_CHK("stop state", exp_stop(ctab[i]), seq_state)
			if (seq_state === ST_DECEL) begin
				`DSS_CHK("decel ticks", exp_scale(f, 60, 600), decel_ticks)
				wait_state(ST_DCB_STOP);
			end
			if (i == 1) begin
				wait_state(ST_DCB_STOP);
				`DSS_CHK("brake current", 8'h32, dcb_current)
			end
			if (i == 4) begin
				run_cmd <= 1'b1;
				ticks(5);
				`DSS_CHK("coast refuse", ST_BB, seq_state)
				run_cmd <= 1'b0;
			end
			wait_state(ST_IDLE);
			if (i == 2) begin
				run_cmd <= 1'b1;
				ticks(20);
				`DSS_CHK("timed inhibit", ST_IDLE, seq_state)
				run_cmd <= 1'b0;
				ticks(700);
			end
		end
		delay <= 8'd80;
		run_cmd <= 1'b1;
		wait_state(ST_SEARCH);
		wait_state(ST_RUN);
		wb(1'b1, 8'h00, 32'h0);
		run_cmd <= 1'b0;
		wait_state(ST_IDLE);
		// Start braking, then pre-excitation
		delay <= 8'd20;
		wb(1'b1, 8'h0C, 32'h0002_0032);
		wb(1'b1, 8'h14, 32'h00C8_0004);
		run_cmd <= 1'b1;
		wait_state(ST_DCB_START);
		`DSS_CHK("start brake", 1'b1, dcb_active)
		wait_state(ST_PREX);
		`DSS_CHK("prex level", 8'hC8, prex_level)
		wait_state(ST_RUN);
		wb(1'b1, 8'h00, 32'hC);
		run_cmd <= 1'b0;
		k = 0;
		for (int n = 0; n < 3000 && seq_state !== ST_IDLE; n++) begin
			ticks(1);
			if (dcb_active === 1'b1) k++;
		end
		run_cmd <= 1'b1;
		ticks(3);
		`DSS_CHK("sensor start", ST_PREX, seq_state)
		run_cmd <= 1'b0;
		wait_state(ST_IDLE);
		`DSS_CHK("sensor brake", 0, k)
		// Input functions: conflict and braking
		wb(1'b1, 8'h1C, 32'h0000_2213);
		`DSS_CHK("assign warn", 1'b1, warn)
		wb(1'b1, 8'h1C, 32'h0000_0021);
		`DSS_CHK("assign ok", 1'b0, warn)
		mfi_in <= 6'($urandom) | 6'h01;
		ticks(2);
		`DSS_CHK("sensor input", 1'b0, dcb_active)
		wb(1'b1, 8'h00, 32'h0);
		ticks(2);
		`DSS_CHK("input brake", 1'b1, dcb_active)
		mfi_in <= 6'h00;
		wb(1'b1, 8'h1C, 32'h0);
		// Undervoltage with zero filter time
		wb(1'b1, 8'h18, 32'h0000_0190);
		run_cmd <= 1'b1;
		wait_state(ST_RUN);
		bus_voltage <= 10'd350;
		ticks(3);
		`DSS_CHK("uv fault", 1'b1, undervoltage_fault)
		wait_state(ST_IDLE);
		bus_voltage <= 10'd500;
		run_cmd <= 1'b0;
		ticks(2);
		run_cmd <= 1'b1;
		ticks(40);
		`DSS_CHK("no restart", ST_IDLE, seq_state)
		run_cmd <= 1'b0;
		wb(1'b1, 8'h28, 32'h1);
		ticks(1);
		`DSS_CHK("uv clear", 1'b0, undervoltage_fault)
		test_done();
	end
endmodule : dss_sequencer_bench
